// file: design/sacmw_pkg.sv
package sacmw_pkg;

	// widths
	localparam int RES_W   = 10;
	localparam int ADDR_W  = 4;
	localparam int DATA_W  = 8;
	localparam int CODE_W  = 4;

	// register offsets
	localparam logic [3:0] OFS_CTRL     = 4'h0;
	localparam logic [3:0] OFS_CHSEL    = 4'h1;
	localparam logic [3:0] OFS_PAIRCFG  = 4'h2;
	localparam logic [3:0] OFS_STATUS   = 4'h3;
	localparam logic [3:0] OFS_MASK     = 4'h4;
	localparam logic [3:0] OFS_RES_HI   = 4'h5;
	localparam logic [3:0] OFS_RES_LO   = 4'h6;
	localparam logic [3:0] OFS_GT_LO    = 4'h7;
	localparam logic [3:0] OFS_GT_HI    = 4'h8;
	localparam logic [3:0] OFS_LT_LO    = 4'h9;
	localparam logic [3:0] OFS_LT_HI    = 4'ha;
	localparam logic [3:0] OFS_STATE    = 4'hb;

	// control fields
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_START  = 1;
	localparam int CTRL_TSEL   = 2;
	localparam int CTRL_BGND   = 4;

	// trigger selections
	localparam logic [1:0] TSEL_SOFT  = 2'h0;
	localparam logic [1:0] TSEL_TIMER = 2'h1;
	localparam logic [1:0] TSEL_EXT   = 2'h2;

	// status and mask fields
	localparam int ST_DONE = 0;
	localparam int ST_WIN  = 1;
	localparam int EVT_W   = 2;

	// reset values
	localparam logic [7:0]       CTRL_RST  = 8'h00;
	localparam logic [3:0]       CHSEL_RST = 4'h0;
	localparam logic [3:0]       PAIR_RST  = 4'h0;
	localparam logic [RES_W-1:0] GT_RST    = 10'h3ff;
	localparam logic [RES_W-1:0] LT_RST    = 10'h000;

	// multiplexer codes
	localparam logic [3:0] CODE_TEMP = 4'h8;

	// timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int CONV_PERIOD_NS = 5000;
	localparam int CONV_MAX_CYC   = CONV_PERIOD_NS / CLK_PERIOD_NS;
	localparam int STEPS          = RES_W + 2;
	localparam int STEP_CYC       = CONV_MAX_CYC / STEPS;

	typedef enum {ST_IDLE, ST_TRACK, ST_CONVERT} sacmw_state_t;

endpackage : sacmw_pkg

// file: design/sacmw_top.sv
`timescale 1ns/1ps
`default_nettype none
module sacmw_top
	import sacmw_pkg::*;
(
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wr_data_in,
	input  wire logic              wr_en_in,
	input  wire logic              rd_en_in,
	output logic      [DATA_W-1:0] rd_data_out,
	input  wire logic              timer_ovf_in,
	input  wire logic              ext_start_in,
	input  wire logic              comp_in,
	output logic      [RES_W-1:0]  dac_code_out,
	output logic                   sample_out,
	output logic                   busy_out,
	output logic      [3:0]        mux_pos_out,
	output logic      [2:0]        mux_neg_out,
	output logic                   mux_diff_out,
	output logic                   irq_out
);

	// register file state
	logic [7:0]       ctrl_reg, ctrl_next;
	logic [3:0]       chsel_reg, chsel_next;
	logic [3:0]       pair_reg, pair_next;
	logic [EVT_W-1:0] status_reg, status_next;
	logic [EVT_W-1:0] mask_reg, mask_next;
	logic [RES_W-1:0] gt_reg, gt_next;
	logic [RES_W-1:0] lt_reg, lt_next;
	logic [RES_W-1:0] result_reg, result_next;
	logic [DATA_W-1:0] rd_data_reg, rd_data_next;
	logic             irq_reg, irq_next;

	// sequencer state
	sacmw_state_t     state_reg, state_next;
	logic [RES_W-1:0] code_reg, code_next;
	logic [3:0]       bit_reg, bit_next;
	logic [7:0]       step_reg, step_next;
	logic [3:0]       pos_reg, pos_next;
	logic [2:0]       neg_reg, neg_next;
	logic             diff_reg, diff_next;

	// pin synchronisers
	logic [1:0] ext_sync_reg;
	logic       ext_prev_reg;
	logic [1:0] comp_sync_reg;

	logic             wr_ctrl;
	logic             soft_start;
	logic             trig_any;
	logic             step_en;
	logic             done_pulse;
	logic [RES_W-1:0] final_code;
	logic             win_hit;
	logic             enable;
	logic             enable_now;
	logic             bgnd;
	logic             busy_reg;
	logic             sample_reg;

	// decode of a register address hit on a strobe
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs,
		input logic en);
		hit = en && (a == ofs);
	endfunction : hit

	assign enable     = ctrl_reg[CTRL_ENABLE];
	assign bgnd       = ctrl_reg[CTRL_BGND];
	assign wr_ctrl    = hit(addr_in, OFS_CTRL, wr_en_in);
	assign soft_start = wr_ctrl && wr_data_in[CTRL_START];
	// enable as written this cycle, so one write can enable and start
	assign enable_now = wr_ctrl ? wr_data_in[CTRL_ENABLE] : enable;

	// two flops on the ext_start_in and comp_in pins before use
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			ext_sync_reg  <= 2'h0;
			ext_prev_reg  <= 1'b0;
			comp_sync_reg <= 2'h0;
		end
		else
		begin
			ext_sync_reg  <= {ext_sync_reg[0], ext_start_in};
			ext_prev_reg  <= ext_sync_reg[1];
			comp_sync_reg <= {comp_sync_reg[0], comp_in};
		end
	end

	always_comb
	begin
		case (ctrl_reg[CTRL_TSEL +: 2])
			TSEL_SOFT:  trig_any = soft_start;
			TSEL_TIMER: trig_any = timer_ovf_in;
			TSEL_EXT:   trig_any = ext_sync_reg[1] && !ext_prev_reg;
			default:    trig_any = 1'b0;
		endcase
	end

	// step divider enable
	assign step_en    = (step_reg == 8'(STEP_CYC - 1));
	assign done_pulse = (state_reg == ST_CONVERT) && step_en && (bit_reg == 4'h0);
	assign final_code = comp_sync_reg[1] ? code_reg : (code_reg & ~(RES_W'(1) << bit_reg));

	// window comparator on the value being latched
	sacmw_window u_window
	(
		.value_in    (final_code),
		.gt_limit_in (gt_reg),
		.lt_limit_in (lt_reg),
		.hit_out     (win_hit)
	);

	// sequencer next state
	always_comb
	begin
		state_next = state_reg;
		code_next  = code_reg;
		bit_next   = bit_reg;
		step_next  = step_en ? 8'h00 : step_reg + 8'h01;
		case (state_reg)
			ST_IDLE:
			begin
				step_next = 8'h00;
				if (enable_now && (trig_any || bgnd))
					state_next = ST_TRACK;
			end
			ST_TRACK:
			begin
				if (step_en)
				begin
					state_next = ST_CONVERT;
					bit_next   = 4'(RES_W - 1);
					code_next  = RES_W'(1) << (RES_W - 1);
				end
			end
			ST_CONVERT:
			begin
				if (step_en)
				begin
					code_next = final_code;
					if (bit_reg == 4'h0)
						state_next = bgnd ? ST_TRACK : ST_IDLE;
					else
					begin
						bit_next  = bit_reg - 4'h1;
						code_next = final_code | (RES_W'(1) << (bit_reg - 4'h1));
					end
				end
			end
			default: state_next = ST_IDLE;
		endcase
		if (!enable_now)
		begin
			state_next = ST_IDLE;
			step_next  = 8'h00;
		end
	end

	// channel routing from code and pair flags
	always_comb
	begin
		pos_next  = chsel_reg;
		neg_next  = 3'h0;
		diff_next = 1'b0;
		if (chsel_reg >= CODE_TEMP)
			pos_next = CODE_TEMP;
		// paired codes swap sign inside a pair
		else if (pair_reg[chsel_reg[2:1]])
		begin
			diff_next = 1'b1;
			neg_next  = {chsel_reg[2:1], ~chsel_reg[0]};
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			state_reg <= ST_IDLE;
			code_reg  <= '0;
			bit_reg   <= 4'h0;
			step_reg  <= 8'h00;
			pos_reg   <= 4'h0;
			neg_reg   <= 3'h0;
			diff_reg  <= 1'b0;
			busy_reg   <= 1'b0;
			sample_reg <= 1'b0;
		end
		else
		begin
			busy_reg   <= (state_next != ST_IDLE);
			sample_reg <= (state_next == ST_TRACK);
			state_reg <= state_next;
			code_reg  <= code_next;
			bit_reg   <= bit_next;
			step_reg  <= step_next;
			pos_reg   <= pos_next;
			neg_reg   <= neg_next;
			diff_reg  <= diff_next;
		end
	end

	// register writes, sticky events and read mux
	always_comb
	begin
		ctrl_next   = ctrl_reg;
		chsel_next  = chsel_reg;
		pair_next   = pair_reg;
		mask_next   = mask_reg;
		gt_next     = gt_reg;
		lt_next     = lt_reg;
		result_next = result_reg;
		status_next = status_reg;
		if (wr_ctrl)
			ctrl_next = wr_data_in & ~(8'h01 << CTRL_START);
		if (hit(addr_in, OFS_CHSEL, wr_en_in))
			chsel_next = wr_data_in[CODE_W-1:0];
		if (hit(addr_in, OFS_PAIRCFG, wr_en_in))
			pair_next = wr_data_in[3:0];
		if (hit(addr_in, OFS_MASK, wr_en_in))
			mask_next = wr_data_in[EVT_W-1:0];
		if (hit(addr_in, OFS_GT_LO, wr_en_in))
			gt_next[7:0] = wr_data_in;
		if (hit(addr_in, OFS_GT_HI, wr_en_in))
			gt_next[RES_W-1:8] = wr_data_in[RES_W-9:0];
		if (hit(addr_in, OFS_LT_LO, wr_en_in))
			lt_next[7:0] = wr_data_in;
		if (hit(addr_in, OFS_LT_HI, wr_en_in))
			lt_next[RES_W-1:8] = wr_data_in[RES_W-9:0];
		if (hit(addr_in, OFS_STATUS, wr_en_in))
			status_next = status_reg & ~wr_data_in[EVT_W-1:0];
		// latch result; sets win over clears
		if (done_pulse)
		begin
			result_next = final_code;
			// done flag, held back in background
			if (!bgnd)
				status_next[ST_DONE] = 1'b1;
			if (win_hit)
				status_next[ST_WIN] = 1'b1;
		end
		irq_next = |(status_next & mask_next);
		rd_data_next = 8'h00;
		if (rd_en_in)
		begin
			case (addr_in)
				OFS_CTRL:    rd_data_next = ctrl_reg;
				OFS_CHSEL:   rd_data_next = {4'h0, chsel_reg};
				OFS_PAIRCFG: rd_data_next = {4'h0, pair_reg};
				OFS_STATUS:  rd_data_next = 8'(status_reg);
				OFS_MASK:    rd_data_next = 8'(mask_reg);
				OFS_RES_HI:  rd_data_next = 8'(result_reg[RES_W-1:8]);
				OFS_RES_LO:  rd_data_next = result_reg[7:0];
				OFS_GT_LO:   rd_data_next = gt_reg[7:0];
				OFS_GT_HI:   rd_data_next = 8'(gt_reg[RES_W-1:8]);
				OFS_LT_LO:   rd_data_next = lt_reg[7:0];
				OFS_LT_HI:   rd_data_next = 8'(lt_reg[RES_W-1:8]);
				OFS_STATE:   rd_data_next = {7'h00, state_reg != ST_IDLE};
				default:     rd_data_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			ctrl_reg    <= CTRL_RST;
			chsel_reg   <= CHSEL_RST;
			pair_reg    <= PAIR_RST;
			mask_reg    <= '0;
			status_reg  <= '0;
			gt_reg      <= GT_RST;
			lt_reg      <= LT_RST;
			result_reg  <= '0;
			rd_data_reg <= 8'h00;
			irq_reg     <= 1'b0;
		end
		else
		begin
			ctrl_reg    <= ctrl_next;
			chsel_reg   <= chsel_next;
			pair_reg    <= pair_next;
			mask_reg    <= mask_next;
			status_reg  <= status_next;
			gt_reg      <= gt_next;
			lt_reg      <= lt_next;
			result_reg  <= result_next;
			rd_data_reg <= rd_data_next;
			irq_reg     <= irq_next;
		end
	end

	// outputs straight from flops
	assign rd_data_out  = rd_data_reg;
	assign irq_out      = irq_reg;
	assign dac_code_out = code_reg;
	assign sample_out   = sample_reg;
	assign busy_out     = busy_reg;
	assign mux_pos_out  = pos_reg;
	assign mux_neg_out  = neg_reg;
	assign mux_diff_out = diff_reg;

	// cycles spent in one conversion
	logic [9:0] conv_cnt_reg;
	always_ff @(posedge clock_in)
	begin
		if (rst_in || state_reg == ST_IDLE || done_pulse)
			conv_cnt_reg <= 10'h000;
		else
			conv_cnt_reg <= conv_cnt_reg + 10'h001;
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	property p_trigger_start;
		(state_reg == ST_IDLE) && enable_now && trig_any |=> (state_reg == ST_TRACK);
	endproperty
	a_trigger_start: assert property (p_trigger_start) else $error("trigger not taken");

	property p_done_flag;
		done_pulse && !bgnd |=> status_reg[ST_DONE];
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("done flag missing");

	property p_irq_gate;
		##1 (irq_out == |(status_reg & mask_reg));
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt not masked status");

	property p_result_latch;
		done_pulse ##1 rd_en_in && (addr_in == OFS_RES_LO)
			|=> rd_data_out == $past(result_reg[7:0]);
	endproperty
	a_result_latch: assert property (p_result_latch) else $error("result low wrong");

	property p_window_flag;
		done_pulse && win_hit |=> status_reg[ST_WIN];
	endproperty
	a_window_flag: assert property (p_window_flag) else $error("window flag missing");

	property p_bgnd_quiet;
		done_pulse && bgnd && !status_reg[ST_DONE] |=> !status_reg[ST_DONE];
	endproperty
	a_bgnd_quiet: assert property (p_bgnd_quiet) else $error("done set in background");

	property p_shutdown;
		!enable && !enable_now |=> (state_reg == ST_IDLE) && !busy_out;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("converting while shut down");

	property p_mux_pair;
		mux_diff_out |-> (mux_pos_out[2:1] == mux_neg_out[2:1])
			&& (mux_pos_out[0] != mux_neg_out[0]);
	endproperty
	a_mux_pair: assert property (p_mux_pair) else $error("pair routing wrong");

	property p_chsel_upper;
		rd_en_in && (addr_in == OFS_CHSEL) |=> rd_data_out[7:4] == 4'h0;
	endproperty
	a_chsel_upper: assert property (p_chsel_upper) else $error("upper bits not zero");

	property p_rate;
		conv_cnt_reg < 10'(CONV_MAX_CYC);
	endproperty
	a_rate: assert property (p_rate) else $error("conversion too slow");

	property p_ignore_busy;
		(state_reg == ST_CONVERT) && trig_any && enable |=> (state_reg != ST_TRACK)
			|| $past(done_pulse);
	endproperty
	a_ignore_busy: assert property (p_ignore_busy) else $error("trigger restarted");

endmodule : sacmw_top
`default_nettype wire

// file: design/sacmw_window.sv
`timescale 1ns/1ps
`default_nettype none
module sacmw_window
	import sacmw_pkg::*;
(
	input  wire logic [RES_W-1:0] value_in,
	input  wire logic [RES_W-1:0] gt_limit_in,
	input  wire logic [RES_W-1:0] lt_limit_in,
	output logic                  hit_out
);

	// limits in order give an inside window, reversed give an outside one
	always_comb
	begin
		if (gt_limit_in < lt_limit_in)
			hit_out = (value_in > gt_limit_in) && (value_in < lt_limit_in);
		else
			hit_out = (value_in > gt_limit_in) || (value_in < lt_limit_in);
	end

endmodule : sacmw_window
`default_nettype wire

// file: testbench/sar_adc_control_mux_window_test.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_mux_window_test
	import sacmw_pkg::*;
;
	logic              clock_in;
	logic              rst_in;
	logic [ADDR_W-1:0] addr_in;
	logic [DATA_W-1:0] wr_data_in;
	logic              wr_en_in;
	logic              rd_en_in;
	logic [DATA_W-1:0] rd_data_out;
	logic              timer_ovf_in;
	logic              ext_start_in;
	logic              comp_in;
	logic [RES_W-1:0]  dac_code_out;
	logic              sample_out;
	logic              busy_out;
	logic [3:0]        mux_pos_out;
	logic [2:0]        mux_neg_out;
	logic              mux_diff_out;
	logic              irq_out;
	int                err_count;
	int                samples_checked;
	int                cycles;

	sacmw_top dut (
		.clock_in     (clock_in),
		.rst_in       (rst_in),
		.addr_in      (addr_in),
		.wr_data_in   (wr_data_in),
		.wr_en_in     (wr_en_in),
		.rd_en_in     (rd_en_in),
		.rd_data_out  (rd_data_out),
		.timer_ovf_in (timer_ovf_in),
		.ext_start_in (ext_start_in),
		.comp_in      (comp_in),
		.dac_code_out (dac_code_out),
		.sample_out   (sample_out),
		.busy_out     (busy_out),
		.mux_pos_out  (mux_pos_out),
		.mux_neg_out  (mux_neg_out),
		.mux_diff_out (mux_diff_out),
		.irq_out      (irq_out)
	);

	// free running 100 mhz clock
	initial
	begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end

	// verdict and end of run
	task automatic conclude();
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	// hang guard, well above the expected run
	always @(posedge clock_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_count++;
			conclude();
		end
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// one-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr_in    <= a;
		wr_data_in <= d;
		wr_en_in   <= 1'b1;
		@(posedge clock_in);
		wr_en_in   <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
		@(posedge clock_in);
		addr_in  <= a;
		rd_en_in <= 1'b1;
		@(posedge clock_in);
		rd_en_in <= 1'b0;
		#1;
		chk(name, {8'h00, exp}, {8'h00, rd_data_out});
	endtask : rd

	// bounded wait for the busy level
	task automatic wait_busy(input logic lvl, input int limit, input string name);
		int n;
		n = 0;
		while (busy_out !== lvl && n < limit)
		begin
			@(posedge clock_in);
			#1;
			n++;
		end
		chk(name, {15'h0, lvl}, {15'h0, busy_out});
	endtask : wait_busy

	// mux outputs settle one cycle after the register
	task automatic mux(input logic [3:0] pos, input logic [2:0] neg, input logic diff);
		repeat (2) @(posedge clock_in);
		#1;
		chk("mux_pos", {12'h0, pos}, {12'h0, mux_pos_out});
		chk("mux_diff", {15'h0, diff}, {15'h0, mux_diff_out});
		if (diff)
			chk("mux_neg", {13'h0, neg}, {13'h0, mux_neg_out});
	endtask : mux

	task automatic chk_irq(input logic exp);
		repeat (2) @(posedge clock_in);
		#1;
		chk("irq", {15'h0, exp}, {15'h0, irq_out});
	endtask : chk_irq

	task automatic t_reset();
		rd(OFS_CHSEL, 8'h00, "chsel");
		rd(OFS_GT_LO, 8'hff, "gt_lo");
		rd(OFS_GT_HI, 8'h03, "gt_hi");
		rd(OFS_LT_LO, 8'h00, "lt_lo");
		rd(OFS_STATUS, 8'h00, "status");
		rd(4'hc, 8'h00, "unmapped");
		chk_irq(1'b0);
	endtask : t_reset

	task automatic t_mux();
		wr(OFS_CHSEL, 8'hf3);
		rd(OFS_CHSEL, 8'h03, "chsel_upper");
		mux(4'h3, 3'h0, 1'b0);
		wr(OFS_PAIRCFG, 8'h02);
		mux(4'h3, 3'h2, 1'b1);
		wr(OFS_CHSEL, 8'h00);
		wr(OFS_PAIRCFG, 8'h01);
		mux(4'h0, 3'h1, 1'b1);
		wr(OFS_CHSEL, 8'h08);
		mux(CODE_TEMP, 3'h0, 1'b0);
		wr(OFS_PAIRCFG, 8'h00);
		wr(OFS_CHSEL, 8'h00);
	endtask : t_mux

	// soft start, retrigger ignored, completion flag
	task automatic t_soft();
		comp_in <= 1'b1;
		wr(OFS_CTRL, 8'h03);
		wait_busy(1'b1, 3, "busy_soft");
		chk("sample", 16'h1, {15'h0, sample_out});
		wr(OFS_CTRL, 8'h03);
		wait_busy(1'b0, 500, "conv_time");
		chk("dac_code", 16'h03ff, {6'h0, dac_code_out});
		chk("sample_idle", 16'h0, {15'h0, sample_out});
		repeat (20) @(posedge clock_in);
		chk("busy_after", 16'h0, {15'h0, busy_out});
		rd(OFS_RES_HI, 8'h03, "res_hi");
		rd(OFS_RES_LO, 8'hff, "res_lo");
		rd(OFS_STATUS, 8'h01, "status_done");
		chk_irq(1'b0);
		wr(OFS_MASK, 8'h01);
		chk_irq(1'b1);
		wr(OFS_STATUS, 8'h01);
		chk_irq(1'b0);
	endtask : t_soft

	// timer overflow and external edge triggers
	task automatic t_hw();
		comp_in <= 1'b0;
		wr(OFS_CTRL, 8'h05);
		@(posedge clock_in);
		timer_ovf_in <= 1'b1;
		@(posedge clock_in);
		timer_ovf_in <= 1'b0;
		wait_busy(1'b1, 3, "busy_timer");
		wait_busy(1'b0, 500, "done_timer");
		rd(OFS_RES_LO, 8'h00, "res_lo0");
		rd(OFS_STATUS, 8'h01, "status_nowin");
		wr(OFS_STATUS, 8'h03);
		wr(OFS_LT_LO, 8'h10);
		wr(OFS_CTRL, 8'h09);
		@(posedge clock_in);
		ext_start_in <= 1'b1;
		wait_busy(1'b1, 8, "busy_ext");
		@(posedge clock_in);
		ext_start_in <= 1'b0;
		wait_busy(1'b0, 500, "done_ext");
		rd(OFS_STATUS, 8'h03, "status_win");
		wr(OFS_STATUS, 8'h03);
	endtask : t_hw

	// background mode silent until a window hit
	task automatic t_bgnd();
		wr(OFS_GT_LO, 8'h05);
		wr(OFS_GT_HI, 8'h00);
		wr(OFS_MASK, 8'h03);
		wr(OFS_CTRL, 8'h13);
		repeat (1200) @(posedge clock_in);
		rd(OFS_STATUS, 8'h00, "bg_miss");
		chk_irq(1'b0);
		wr(OFS_GT_LO, 8'hff);
		wr(OFS_GT_HI, 8'h03);
		repeat (1000) @(posedge clock_in);
		rd(OFS_STATUS, 8'h02, "bg_hit");
		chk_irq(1'b1);
	endtask : t_bgnd

	task automatic t_shut();
		wr(OFS_CTRL, 8'h00);
		wait_busy(1'b0, 5, "abort");
		wr(OFS_STATUS, 8'h03);
		wr(OFS_CTRL, 8'h02);
		repeat (20) @(posedge clock_in);
		chk("shut_busy", 16'h0, {15'h0, busy_out});
		rd(OFS_STATUS, 8'h00, "shut_status");
	endtask : t_shut

	// main sequence
	initial
	begin
		err_count       = 0;
		samples_checked = 0;
		cycles          = 0;
		rst_in          = 1'b1;
		addr_in         = 4'h0;
		wr_data_in      = 8'h00;
		wr_en_in        = 1'b0;
		rd_en_in        = 1'b0;
		timer_ovf_in    = 1'b0;
		ext_start_in    = 1'b0;
		comp_in         = 1'b0;
		repeat (20) @(posedge clock_in);
		rst_in <= 1'b0;
		t_reset();
		t_mux();
		t_soft();
		t_hw();
		t_bgnd();
		t_shut();
		conclude();
	end
endmodule : sar_adc_control_mux_window_test
`default_nettype wire
